// >>> rtl/slmc_cfg.svh
// Constants for the serial LCD message controller
// Operation
// - Set display address: instruction with bit 7 high, then 40 us execution.
// - Status read returns busy on bit 7, cursor counter below, no delay.
// - Controller runs the 8-bit init sequence itself before message data.
// - Bus is bidirectional; enable, read/write and select are outputs only.
// - Serial line inverted: start high, data complemented, stop low.
// - Rising start edge, mid-bit check, then one sample per bit period.
// - Bit timer interval is fixed at 208 us, about 4808 baud.
// - After a valid start only bit-timer ticks advance the receiver.
// - Start gone at mid-bit means noise; ignore and await the next edge.
// - Missing stop bit sets the frame-error flag.
// - Good frame sets the new-character flag for the message handler.
// - Character 10h ends message, pads to 16 spaces, writes the display.
// - Character 13h is dropped without touching the buffer.
// - Other characters are stored at the current position; pointer advances.
// - Over 16 characters without terminator: auto display, restart at start.
// - Display write sends all 16 buffer entries in order as data writes.
// - Two groups of eight, with a line-two address instruction between them.
// - After initialisation the controller shows a ready message.
// - A flagged frame error shows a frame-error message.
// - Frame is one start, eight data, no parity, one stop bit.
// - Function set selects the 8-bit bus with its width bit set.
`ifndef SLMC_CFG_SVH
`define SLMC_CFG_SVH
`define SLMC_CLK_NS 4
`define SLMC_BIT_NS 208000
`define SLMC_BIT_CYC (`SLMC_BIT_NS / `SLMC_CLK_NS)
`define SLMC_HALF_CYC (`SLMC_BIT_CYC / 2)
`define SLMC_EXEC_NS 40000
`define SLMC_EXEC_CYC ((`SLMC_EXEC_NS + `SLMC_CLK_NS - 1) / `SLMC_CLK_NS)
`define SLMC_PWR_NS 15000000
`define SLMC_PWR_CYC ((`SLMC_PWR_NS + `SLMC_CLK_NS - 1) / `SLMC_CLK_NS)
`define SLMC_SU_NS 60
`define SLMC_SU_CYC ((`SLMC_SU_NS + `SLMC_CLK_NS - 1) / `SLMC_CLK_NS)
`define SLMC_EPW_NS 480
`define SLMC_EPW_CYC ((`SLMC_EPW_NS + `SLMC_CLK_NS - 1) / `SLMC_CLK_NS)
`define SLMC_HOLD_NS 20
`define SLMC_HOLD_CYC ((`SLMC_HOLD_NS + `SLMC_CLK_NS - 1) / `SLMC_CLK_NS)
`define SLMC_DATA_BITS 3'h7
`define SLMC_CHR_END 8'h10
`define SLMC_CHR_SKIP 8'h13
`define SLMC_CHR_SPACE 8'h20
`define SLMC_INS_ADDR 8'h80
`define SLMC_LINE2_ADDR 8'h40
`define SLMC_INS_FUNC 8'h38
`define SLMC_INS_DISP_ON 8'h0C
`define SLMC_INS_ENTRY 8'h06
`define SLMC_INIT_STEPS 5'h05
`define SLMC_LINE2_STEP 5'h09
`define SLMC_DISP_STEPS 5'h12
`define SLMC_MSG_LEN 5'h10
`define SLMC_BUSY_BIT 7
`define SLMC_RST_BYTE 8'h00
`define SLMC_MSG_READY ">Ready          "
`define SLMC_MSG_FERR ">Frame Error!!! "
`endif

// >>> rtl/slmc_pkg.sv
// Types of the serial LCD message controller
package slmc_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP}
    slmc_rx_state_type;
  typedef enum logic [2:0] {M_PWR, M_INIT, M_IDLE, M_PAD, M_DISP}
    slmc_main_state_type;
  typedef enum logic [2:0] {C_IDLE, C_SU, C_EHI, C_HOLD, C_EXEC,
    P_SU, P_EHI, P_HOLD} slmc_cyc_state_type;
  typedef enum logic [1:0] {MSG_BUF, MSG_READY, MSG_FERR}
    slmc_msg_sel_type;
endpackage : slmc_pkg

// >>> rtl/slmc_msg_mem.sv
// Sixteen-entry message buffer with registered read data
module slmc_msg_mem (
  // Clock
  input wire logic clk_i,
  // Write port
  input wire logic we_i,
  input wire logic [3:0] waddr_i,
  input wire logic [7:0] wdata_i,
  // Read port
  input wire logic [3:0] raddr_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem_r [16];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_r[raddr_i];
  end
endmodule : slmc_msg_mem

// >>> rtl/slmc_top.sv
// Serial receiver, message handler and LCD writer
`include "slmc_cfg.svh"
module slmc_top import slmc_pkg::*; #(
  parameter int unsigned BIT_CYC = `SLMC_BIT_CYC,
  parameter int unsigned HALF_CYC = `SLMC_HALF_CYC,
  parameter int unsigned EXEC_CYC = `SLMC_EXEC_CYC,
  parameter int unsigned PWR_CYC = `SLMC_PWR_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial line
  input wire logic serial_in_pin_i,
  // LCD module bus and controls
  input wire logic [7:0] lcd_bus_i,
  output logic [7:0] lcd_bus_o,
  output logic lcd_bus_oe_n_o,
  output logic lcd_en_o,
  output logic lcd_rw_o,
  output logic instr_data_select_o,
  // Status
  output logic ready_o,
  output logic frame_error_o,
  output logic busy_indicator_o,
  output logic [6:0] cursor_counter_o
);
  // Receiver
  slmc_rx_state_type rx_state_r, rx_state_nxt;
  logic rx_prev_r;
  logic [15:0] rx_cnt_r, rx_cnt_nxt;
  logic [2:0] rx_bit_r, rx_bit_nxt;
  logic [7:0] rx_shift_r, rx_shift_nxt;
  logic [7:0] rx_char_r;
  logic rx_done, rx_ferr;
  logic new_char_r, frame_err_r;
  logic char_take, ferr_take;
  wire rx_rise = serial_in_pin_i & ~rx_prev_r;
  wire rx_tick = (rx_cnt_r == 16'h0000);
  wire [15:0] rx_dec = rx_cnt_r - 16'h0001;

  always_comb begin
    rx_state_nxt = rx_state_r;
    rx_cnt_nxt = rx_tick ? rx_cnt_r : rx_dec;
    rx_bit_nxt = rx_bit_r;
    rx_shift_nxt = rx_shift_r;
    rx_done = 1'b0;
    rx_ferr = 1'b0;
    case (rx_state_r)
      RX_IDLE: begin
        if (rx_rise) begin
          rx_state_nxt = RX_START;
          rx_cnt_nxt = 16'(HALF_CYC - 1);
        end
      end
      RX_START: begin
        if (rx_tick) begin
          if (serial_in_pin_i) begin
            rx_state_nxt = RX_DATA;
            rx_cnt_nxt = 16'(BIT_CYC - 1);
            rx_bit_nxt = 3'h0;
          end else begin
            rx_state_nxt = RX_IDLE;
          end
        end
      end
      RX_DATA: begin
        if (rx_tick) begin
          rx_shift_nxt = {~serial_in_pin_i, rx_shift_r[7:1]};
          rx_cnt_nxt = 16'(BIT_CYC - 1);
          rx_bit_nxt = rx_bit_r + 3'h1;
          if (rx_bit_r == `SLMC_DATA_BITS) begin
            rx_state_nxt = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (rx_tick) begin
          rx_state_nxt = RX_IDLE;
          rx_done = ~serial_in_pin_i;
          rx_ferr = serial_in_pin_i;
        end
      end
      default: rx_state_nxt = RX_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_state_r <= RX_IDLE;
      rx_prev_r <= 1'b0;
      rx_cnt_r <= 16'h0000;
      rx_bit_r <= 3'h0;
      rx_shift_r <= `SLMC_RST_BYTE;
    end else begin
      rx_state_r <= rx_state_nxt;
      rx_prev_r <= serial_in_pin_i;
      rx_cnt_r <= rx_cnt_nxt;
      rx_bit_r <= rx_bit_nxt;
      rx_shift_r <= rx_shift_nxt;
    end
  end

  // Flags: a new event wins over the clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_char_r <= `SLMC_RST_BYTE;
      new_char_r <= 1'b0;
      frame_err_r <= 1'b0;
    end else begin
      if (rx_done) begin
        rx_char_r <= rx_shift_r;
      end
      new_char_r <= rx_done | (new_char_r & ~char_take);
      frame_err_r <= rx_ferr | (frame_err_r & ~ferr_take);
    end
  end

  // Message handler
  slmc_main_state_type m_state_r, m_state_nxt;
  slmc_msg_sel_type msg_sel_r, msg_sel_nxt;
  logic [21:0] tmr_r;
  logic [4:0] step_r, step_nxt;
  logic [4:0] wr_ptr_r, wr_ptr_nxt;
  logic [7:0] pend_r, pend_nxt;
  logic pend_v_r, pend_v_nxt;
  logic ready_r, ready_nxt;
  logic mem_we;
  logic [3:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic cyc_go;
  logic cyc_busy;

  wire disp_instr = (step_r == 5'h00) || (step_r == `SLMC_LINE2_STEP);
  wire [3:0] disp_idx = (step_r < `SLMC_LINE2_STEP) ?
    4'(step_r - 5'h01) : 4'(step_r - 5'h02);
  wire [127:0] rom_msg = (msg_sel_r == MSG_READY) ?
    `SLMC_MSG_READY : `SLMC_MSG_FERR;
  wire [7:0] rom_chr = rom_msg[7'd127 - {disp_idx, 3'b000} -: 8];
  wire [7:0] line_ins = (step_r == 5'h00) ? `SLMC_INS_ADDR :
    (`SLMC_INS_ADDR | `SLMC_LINE2_ADDR);
  wire [7:0] disp_byte = disp_instr ? line_ins :
    ((msg_sel_r == MSG_BUF) ? mem_rdata : rom_chr);
  wire [7:0] init_byte = (step_r < 5'h03) ? `SLMC_INS_FUNC :
    ((step_r == 5'h03) ? `SLMC_INS_DISP_ON : `SLMC_INS_ENTRY);
  wire [7:0] cyc_byte = (m_state_r == M_INIT) ? init_byte : disp_byte;
  wire cyc_rs = (m_state_r == M_DISP) && !disp_instr;
  wire pwr_done = (tmr_r == 22'(PWR_CYC - 1));

  always_comb begin
    m_state_nxt = m_state_r;
    msg_sel_nxt = msg_sel_r;
    step_nxt = step_r;
    wr_ptr_nxt = wr_ptr_r;
    pend_nxt = pend_r;
    pend_v_nxt = pend_v_r;
    ready_nxt = ready_r;
    mem_we = 1'b0;
    mem_waddr = wr_ptr_r[3:0];
    mem_wdata = rx_char_r;
    cyc_go = 1'b0;
    char_take = 1'b0;
    ferr_take = 1'b0;
    case (m_state_r)
      M_PWR: begin
        if (pwr_done) begin
          m_state_nxt = M_INIT;
          step_nxt = 5'h00;
        end
      end
      M_INIT: begin
        if (!cyc_busy) begin
          if (step_r == `SLMC_INIT_STEPS) begin
            m_state_nxt = M_DISP;
            msg_sel_nxt = MSG_READY;
            step_nxt = 5'h00;
          end else begin
            cyc_go = 1'b1;
            step_nxt = step_r + 5'h01;
          end
        end
      end
      M_DISP: begin
        if (!cyc_busy) begin
          if (step_r == `SLMC_DISP_STEPS) begin
            m_state_nxt = M_IDLE;
            step_nxt = 5'h00;
            ready_nxt = 1'b1;
            if (msg_sel_r == MSG_BUF) begin
              wr_ptr_nxt = 5'h00;
            end
          end else begin
            cyc_go = 1'b1;
            step_nxt = step_r + 5'h01;
          end
        end
      end
      M_IDLE: begin
        if (pend_v_r) begin
          mem_we = 1'b1;
          mem_waddr = 4'h0;
          mem_wdata = pend_r;
          wr_ptr_nxt = 5'h01;
          pend_v_nxt = 1'b0;
        end else if (frame_err_r) begin
          ferr_take = 1'b1;
          msg_sel_nxt = MSG_FERR;
          m_state_nxt = M_DISP;
        end else if (new_char_r) begin
          char_take = 1'b1;
          if (rx_char_r == `SLMC_CHR_END) begin
            m_state_nxt = M_PAD;
          end else if (rx_char_r == `SLMC_CHR_SKIP) begin
            m_state_nxt = M_IDLE;
          end else if (wr_ptr_r == `SLMC_MSG_LEN) begin
            pend_nxt = rx_char_r;
            pend_v_nxt = 1'b1;
            msg_sel_nxt = MSG_BUF;
            m_state_nxt = M_DISP;
          end else begin
            mem_we = 1'b1;
            wr_ptr_nxt = wr_ptr_r + 5'h01;
          end
        end
      end
      M_PAD: begin
        if (wr_ptr_r == `SLMC_MSG_LEN) begin
          msg_sel_nxt = MSG_BUF;
          m_state_nxt = M_DISP;
        end else begin
          mem_we = 1'b1;
          mem_wdata = `SLMC_CHR_SPACE;
          wr_ptr_nxt = wr_ptr_r + 5'h01;
        end
      end
      default: m_state_nxt = M_PWR;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      m_state_r <= M_PWR;
      msg_sel_r <= MSG_READY;
      tmr_r <= 22'h000000;
      step_r <= 5'h00;
      wr_ptr_r <= 5'h00;
      pend_r <= `SLMC_RST_BYTE;
      pend_v_r <= 1'b0;
      ready_r <= 1'b0;
    end else begin
      m_state_r <= m_state_nxt;
      msg_sel_r <= msg_sel_nxt;
      tmr_r <= pwr_done ? tmr_r : tmr_r + 22'h000001;
      step_r <= step_nxt;
      wr_ptr_r <= wr_ptr_nxt;
      pend_r <= pend_nxt;
      pend_v_r <= pend_v_nxt;
      ready_r <= ready_nxt;
    end
  end

  slmc_msg_mem u_mem (
    .clk_i(clk_i),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(mem_wdata),
    .raddr_i(disp_idx),
    .rdata_o(mem_rdata)
  );

  // LCD bus cycle engine
  slmc_cyc_state_type c_state_r, c_state_nxt;
  logic [13:0] c_cnt_r, c_cnt_nxt;
  logic [7:0] bus_nxt;
  logic oe_n_nxt, en_nxt, rw_nxt, rs_nxt, busy_nxt;
  logic [6:0] cur_nxt;
  wire c_tick = (c_cnt_r == 14'h0000);
  wire [13:0] c_dec = c_cnt_r - 14'h0001;
  assign cyc_busy = (c_state_r != C_IDLE);

  always_comb begin
    c_state_nxt = c_state_r;
    c_cnt_nxt = c_tick ? c_cnt_r : c_dec;
    bus_nxt = lcd_bus_o;
    oe_n_nxt = lcd_bus_oe_n_o;
    en_nxt = lcd_en_o;
    rw_nxt = lcd_rw_o;
    rs_nxt = instr_data_select_o;
    busy_nxt = busy_indicator_o;
    cur_nxt = cursor_counter_o;
    case (c_state_r)
      C_IDLE: begin
        if (cyc_go) begin
          bus_nxt = cyc_byte;
          rs_nxt = cyc_rs;
          rw_nxt = 1'b0;
          oe_n_nxt = 1'b0;
          c_cnt_nxt = 14'(`SLMC_SU_CYC - 1);
          c_state_nxt = C_SU;
        end
      end
      C_SU, P_SU: begin
        if (c_tick) begin
          en_nxt = 1'b1;
          c_cnt_nxt = 14'(`SLMC_EPW_CYC - 1);
          c_state_nxt = (c_state_r == C_SU) ? C_EHI : P_EHI;
        end
      end
      C_EHI: begin
        if (c_tick) begin
          en_nxt = 1'b0;
          c_cnt_nxt = 14'(`SLMC_HOLD_CYC - 1);
          c_state_nxt = C_HOLD;
        end
      end
      C_HOLD: begin
        if (c_tick) begin
          oe_n_nxt = 1'b1;
          c_cnt_nxt = 14'(EXEC_CYC - 1);
          c_state_nxt = C_EXEC;
        end
      end
      C_EXEC: begin
        if (c_tick) begin
          rs_nxt = 1'b0;
          rw_nxt = 1'b1;
          c_cnt_nxt = 14'(`SLMC_SU_CYC - 1);
          c_state_nxt = P_SU;
        end
      end
      P_EHI: begin
        if (c_tick) begin
          en_nxt = 1'b0;
          busy_nxt = lcd_bus_i[`SLMC_BUSY_BIT];
          cur_nxt = lcd_bus_i[6:0];
          c_cnt_nxt = 14'(`SLMC_HOLD_CYC - 1);
          c_state_nxt = P_HOLD;
        end
      end
      P_HOLD: begin
        if (c_tick) begin
          if (busy_indicator_o) begin
            c_cnt_nxt = 14'(`SLMC_SU_CYC - 1);
            c_state_nxt = P_SU;
          end else begin
            rw_nxt = 1'b0;
            c_state_nxt = C_IDLE;
          end
        end
      end
      default: c_state_nxt = C_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      c_state_r <= C_IDLE;
      c_cnt_r <= 14'h0000;
      lcd_bus_o <= `SLMC_RST_BYTE;
      lcd_bus_oe_n_o <= 1'b1;
      lcd_en_o <= 1'b0;
      lcd_rw_o <= 1'b0;
      instr_data_select_o <= 1'b0;
      busy_indicator_o <= 1'b0;
      cursor_counter_o <= 7'h00;
    end else begin
      c_state_r <= c_state_nxt;
      c_cnt_r <= c_cnt_nxt;
      lcd_bus_o <= bus_nxt;
      lcd_bus_oe_n_o <= oe_n_nxt;
      lcd_en_o <= en_nxt;
      lcd_rw_o <= rw_nxt;
      instr_data_select_o <= rs_nxt;
      busy_indicator_o <= busy_nxt;
      cursor_counter_o <= cur_nxt;
    end
  end

  assign ready_o = ready_r;
  assign frame_error_o = frame_err_r;
endmodule : slmc_top

// >>> verif/slmc_top_monitor.sv
// Port assertions of the serial LCD message controller
module slmc_top_monitor #(
  parameter int unsigned EXEC_CYC = 50
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial line and LCD side
  input wire logic serial_in_pin_i,
  input wire logic [7:0] lcd_bus_i,
  input wire logic [7:0] lcd_bus_o,
  input wire logic lcd_bus_oe_n_o,
  input wire logic lcd_en_o,
  input wire logic lcd_rw_o,
  input wire logic instr_data_select_o,
  // Status
  input wire logic ready_o,
  input wire logic frame_error_o,
  input wire logic busy_indicator_o,
  input wire logic [6:0] cursor_counter_o
);
  logic en_q_r;
  logic wr_last_r;
  logic [2:0] ins_cnt_r;
  logic [4:0] dat_cnt_r;
  logic [15:0] gap_r;
  logic rise;
  logic ins_w;
  assign rise = lcd_en_o && !en_q_r;
  assign ins_w = rise && !lcd_rw_o && !instr_data_select_o;
  // Counts writes and cycles since the enable fell
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_q_r <= 1'b0;
      wr_last_r <= 1'b0;
      ins_cnt_r <= 3'h0;
      dat_cnt_r <= 5'h00;
      gap_r <= 16'h0000;
    end else begin
      en_q_r <= lcd_en_o;
      if (rise) wr_last_r <= !lcd_rw_o;
      if (ins_w && ins_cnt_r < 3'h5) ins_cnt_r <= ins_cnt_r + 3'h1;
      // Data writes since the line-one address of the current message
      if (ins_w && lcd_bus_o == 8'h80) dat_cnt_r <= 5'h00;
      else if (rise && instr_data_select_o) dat_cnt_r <= dat_cnt_r + 5'h01;
      if (en_q_r && !lcd_en_o) gap_r <= 16'h0000;
      else if (gap_r != 16'hFFFF) gap_r <= gap_r + 16'h0001;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_en_hold; lcd_en_o [*8]; endsequence
  sequence s_ins_rise; $rose(lcd_en_o) && !lcd_rw_o && !instr_data_select_o;
  endsequence
  property p_rd_release; lcd_rw_o |-> lcd_bus_oe_n_o && !instr_data_select_o;
  endproperty
  a_rd_release: assert property (p_rd_release)
    else $error("bus driven during status read");
  property p_ctl_stable; lcd_en_o && $past(lcd_en_o) |-> $stable(lcd_bus_o)
    && $stable(lcd_rw_o) && $stable(instr_data_select_o); endproperty
  a_ctl_stable: assert property (p_ctl_stable)
    else $error("bus or controls moved while enable high");
  property p_en_width; $rose(lcd_en_o) |-> s_en_hold; endproperty
  a_en_width: assert property (p_en_width)
    else $error("enable pulse too short");
  property p_exec; $rose(lcd_en_o) && wr_last_r |-> gap_r >= EXEC_CYC;
  endproperty
  a_exec: assert property (p_exec)
    else $error("access before execution time elapsed");
  property p_busy_clear; $rose(lcd_en_o) && !lcd_rw_o |-> !busy_indicator_o;
  endproperty
  a_busy_clear: assert property (p_busy_clear)
    else $error("write issued while module busy");
  property p_init_first; $rose(lcd_en_o) && instr_data_select_o
    |-> ins_cnt_r == 3'h5; endproperty
  a_init_first: assert property (p_init_first)
    else $error("data written before initialisation");
  property p_func_8bit; s_ins_rise ##0 ins_cnt_r < 3'h3 |-> lcd_bus_o[4];
  endproperty
  a_func_8bit: assert property (p_func_8bit)
    else $error("function set without 8-bit width");
  property p_addr_ins; s_ins_rise ##0 ins_cnt_r == 3'h5
    |-> lcd_bus_o == (dat_cnt_r == 5'h08 ? 8'hC0 : 8'h80); endproperty
  a_addr_ins: assert property (p_addr_ins)
    else $error("wrong display address instruction");
  property p_ferr_stop; $rose(frame_error_o) |-> $past(serial_in_pin_i);
  endproperty
  a_ferr_stop: assert property (p_ferr_stop)
    else $error("frame error without bad stop bit");
endmodule : slmc_top_monitor
bind slmc_top slmc_top_monitor #(.EXEC_CYC(EXEC_CYC)) slmc_top_monitor_inst (
  .clk_i(clk_i), .rst_i(rst_i), .serial_in_pin_i(serial_in_pin_i),
  .lcd_bus_i(lcd_bus_i), .lcd_bus_o(lcd_bus_o),
  .lcd_bus_oe_n_o(lcd_bus_oe_n_o), .lcd_en_o(lcd_en_o),
  .lcd_rw_o(lcd_rw_o), .instr_data_select_o(instr_data_select_o),
  .ready_o(ready_o), .frame_error_o(frame_error_o),
  .busy_indicator_o(busy_indicator_o), .cursor_counter_o(cursor_counter_o));

// >>> verif/slmc_lcd_model.sv
// Character LCD module model: logs writes, answers status reads
module slmc_lcd_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Module pins
  input wire logic en_i,
  input wire logic rw_i,
  input wire logic sel_i,
  input wire logic [7:0] bus_i,
  output logic [7:0] bus_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] log_q [$];
  logic [6:0] addr_r;
  logic [7:0] last_r;
  logic en_r;
  int busy_reads = 0;
  int busy_left;
  // Status read gives busy and cursor; otherwise a changing pattern
  assign bus_o = (rw_i && !sel_i) ? {busy_left > 0, addr_r} : ~last_r;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_r <= 1'b0;
      addr_r <= 7'h00;
      last_r <= 8'h00;
      busy_left <= 0;
    end else begin
      en_r <= en_i;
      last_r <= bus_i;
      if (en_r && !en_i && rw_i && busy_left > 0) begin
        busy_left <= busy_left - 1;
      end else if (en_r && !en_i && !rw_i) begin
        log_q.push_back({sel_i, bus_i});
        busy_left <= busy_reads;
        if (!sel_i && bus_i[7]) addr_r <= bus_i[6:0];
        else if (sel_i) addr_r <= addr_r + 7'h01;
      end
    end
  end
endmodule : slmc_lcd_model

// >>> verif/slmc_top_bench.sv
// Self-checking bench of the serial LCD message controller
module slmc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = 40;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic serial_in_pin_i = 1'b0;
  logic ferr_seen = 1'b0;
  logic [7:0] lcd_wire, lcd_bus_o, lcd_model;
  logic lcd_bus_oe_n_o, lcd_en_o, lcd_rw_o, instr_data_select_o;
  logic ready_o, frame_error_o, busy_indicator_o;
  logic [6:0] cursor_counter_o;
  logic [7:0] init_b [5] = '{8'h38, 8'h38, 8'h38, 8'h0C, 8'h06};
  int mismatches = 0;
  int checks = 0;
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) if (frame_error_o === 1'b1) ferr_seen <= 1'b1;
  assign lcd_wire = lcd_bus_oe_n_o ? lcd_model : lcd_bus_o;
  slmc_top #(.BIT_CYC(BIT), .HALF_CYC(20), .EXEC_CYC(50), .PWR_CYC(100))
    slmc_top_inst (.clk_i(clk_i), .rst_i(rst_i),
    .serial_in_pin_i(serial_in_pin_i), .lcd_bus_i(lcd_wire),
    .lcd_bus_o(lcd_bus_o), .lcd_bus_oe_n_o(lcd_bus_oe_n_o),
    .lcd_en_o(lcd_en_o), .lcd_rw_o(lcd_rw_o),
    .instr_data_select_o(instr_data_select_o), .ready_o(ready_o),
    .frame_error_o(frame_error_o), .busy_indicator_o(busy_indicator_o),
    .cursor_counter_o(cursor_counter_o));
  slmc_lcd_model slmc_lcd_model_inst (.clk_i(clk_i), .rst_i(rst_i),
    .en_i(lcd_en_o), .rw_i(lcd_rw_o), .sel_i(instr_data_select_o),
    .bus_i(lcd_wire), .bus_o(lcd_model));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk_val(input logic [8:0] got, input logic [8:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_log(input logic [8:0] exp);
    logic [8:0] got;
    got = 9'h1FF;
    if (slmc_lcd_model_inst.log_q.size() > 0) begin
      got = slmc_lcd_model_inst.log_q.pop_front();
    end
    chk_val(got, exp);
  endtask : chk_log
  task automatic wait_log(input int n);
    for (int k = 0; k < 40000; k++) begin
      if (slmc_lcd_model_inst.log_q.size() >= n) break;
      @(posedge clk_i);
    end
  endtask : wait_log
  task automatic send(input logic [7:0] ch, input logic stop_ok);
    logic [9:0] fr;
    fr = {~stop_ok, ~ch, 1'b1};
    for (int i = 0; i < 10; i++) begin
      serial_in_pin_i <= fr[i];
      repeat (BIT) @(posedge clk_i);
    end
    serial_in_pin_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : send
  task automatic send_str(input string s);
    foreach (s[i]) send(s[i], 1'b1);
  endtask : send_str
  task automatic expect_disp(input string s);
    logic [7:0] c;
    wait_log(18);
    chk_log(9'h080);
    for (int i = 0; i < 16; i++) begin
      c = i < s.len() ? s[i] : 8'h20;
      if (i == 8) chk_log(9'h0C0);
      chk_log({1'b1, c});
    end
  endtask : expect_disp
  task automatic t_init;
    wait_log(5);
    foreach (init_b[i]) chk_log({1'b0, init_b[i]});
    expect_disp(">Ready");
    for (int k = 0; k < 2000 && ready_o !== 1'b1; k++) @(posedge clk_i);
    chk_val({8'h00, ready_o}, 9'h001);
    chk_val({2'b00, cursor_counter_o}, 9'h048);
    chk_val({8'h00, busy_indicator_o}, 9'h000);
    $display("test init done");
  endtask : t_init
  task automatic t_msg;
    send_str("Hi");
    send(8'h13, 1'b1);
    send(8'h10, 1'b1);
    expect_disp("Hi");
    $display("test message done");
  endtask : t_msg
  task automatic t_over;
    send_str("ABCDEFGHIJKLMNOP");
    send(8'h51, 1'b1);
    expect_disp("ABCDEFGHIJKLMNOP");
    send(8'h10, 1'b1);
    expect_disp("Q");
    $display("test overflow done");
  endtask : t_over
  task automatic t_ferr;
    slmc_lcd_model_inst.busy_reads = 2;
    send_str("AB");
    ferr_seen <= 1'b0;
    send(8'h55, 1'b0);
    chk_val({8'h00, ferr_seen}, 9'h001);
    expect_disp(">Frame Error!!! ");
    chk_val({8'h00, frame_error_o}, 9'h000);
    slmc_lcd_model_inst.busy_reads = 0;
    $display("test frame error done");
  endtask : t_ferr
  task automatic t_noise;
    ferr_seen <= 1'b0;
    serial_in_pin_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    serial_in_pin_i <= 1'b0;
    repeat (3 * BIT) @(posedge clk_i);
    chk_val(9'(slmc_lcd_model_inst.log_q.size()), 9'h000);
    chk_val({8'h00, ferr_seen}, 9'h000);
    send(8'h43, 1'b1);
    send(8'h10, 1'b1);
    expect_disp("ABC");
    $display("test noise done");
  endtask : t_noise
  initial begin
    repeat (90000) @(posedge clk_i);
    mismatches++;
    $display("BAD at %0t: watchdog expired", $time);
    end_sim();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_init();
    t_msg();
    t_over();
    t_ferr();
    t_noise();
    end_sim();
  end
endmodule : slmc_top_bench
